// file: dual_operand_function_select.sv
// Two configurable function units with an AXI4-Lite register slave.
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
// Operation
// RULE1: Two independent units, each with own operands, enable, mode and output.
// RULE2: Enable off makes the output equal the first operand, any mode.
// RULE3: Enable on makes the output the selected operation on both operands.
// RULE4: Mode values 0 to 6 select switch, invert, AND, OR, negate, modulus, compare.
// RULE5: Switch mode with enable on outputs the second operand.
// RULE6: Invert mode with enable on outputs logical inversion of first operand.
// RULE7: AND mode with enable on outputs logical AND of both operands.
// RULE8: OR mode with enable on outputs logical OR of both operands.
// RULE9: Negate mode with enable on outputs the arithmetic negation of first operand.
// RULE10: Modulus mode with enable on outputs absolute value of first operand.
// RULE11: Compare mode with enable on outputs one when first exceeds second, else zero.
// RULE12: Enable may change while running; output follows without reconfiguration.
// RULE13: After reset operands are 0.00 percent and enable is off.
// RULE14: Non-zero operands count as true; logical results are one or zero.
// RULE15: Signed hundredths values; output recomputed and registered each execution tick.
module dual_operand_function_select (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dual_fn_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [dual_fn_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dual_fn_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [dual_fn_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic signed [dual_fn_pkg::DATA_W-1:0] unit0_result,
  output logic signed [dual_fn_pkg::DATA_W-1:0] unit1_result,
  output logic exec_tick
);
  import dual_fn_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Any non-zero value reads as logically true.
  function automatic logic is_true(input logic signed [DATA_W-1:0] v);
    is_true = (v != FIXED_ZERO); // [RULE14]
  endfunction

  function automatic logic signed [DATA_W-1:0] as_fixed(input logic b);
    as_fixed = b ? FIXED_ONE : FIXED_ZERO; // [RULE14]
  endfunction

  function automatic logic signed [DATA_W-1:0] compute(input unit_cfg_t c);
    logic signed [DATA_W-1:0] r;
    r = c.operand_a;
    if (c.enable) begin // [RULE3]
      case (c.mode) // [RULE4]
        MODE_SWITCH: begin
          r = c.operand_b; // [RULE5]
        end
        MODE_LOGIC_INVERT: begin
          r = as_fixed(!is_true(c.operand_a)); // [RULE6]
        end
        MODE_AND: begin
          r = as_fixed(is_true(c.operand_a) && is_true(c.operand_b)); // [RULE7]
        end
        MODE_OR: begin
          r = as_fixed(is_true(c.operand_a) || is_true(c.operand_b)); // [RULE8]
        end
        MODE_NEGATE_VALUE: begin
          r = -c.operand_a; // [RULE9]
        end
        MODE_MODULUS: begin
          r = (c.operand_a < 0) ? -c.operand_a : c.operand_a; // [RULE10]
        end
        MODE_COMPARATOR: begin
          r = as_fixed(c.operand_a > c.operand_b); // [RULE11]
        end
        default: begin
          r = c.operand_a;
        end
      endcase
    end else begin
      r = c.operand_a; // [RULE2]
    end
    compute = r;
  endfunction

  // Merges a written word into an old one, lane by lane.
  function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] data,
                                                    input logic [3:0] strb);
    logic [DATA_W-1:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    merge_lanes = m;
  endfunction

  // Unit index of an address, or NUM_UNITS when the address is outside both units.
  function automatic int unsigned unit_of(input logic [ADDR_W-1:0] a);
    if ((a & 8'hf0) == OFS_UNIT0) begin
      unit_of = 0;
    end else if ((a & 8'hf0) == OFS_UNIT1) begin
      unit_of = 1;
    end else begin
      unit_of = NUM_UNITS;
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  unit_cfg_t cfg [NUM_UNITS]; // [RULE1]
  logic signed [DATA_W-1:0] result [NUM_UNITS];
  logic [TICK_W-1:0] tick_div;
  logic [DATA_W-1:0] tick_count;
  logic aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic w_held;
  logic [DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic ar_take;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] next_rresp;
  logic write_ok;

  // ----------------------------------------------------------------
  // Execution tick divider
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_div <= '0;
      exec_tick <= 1'b0;
    end else if (tick_div == TICK_LAST) begin
      tick_div <= '0;
      exec_tick <= 1'b1;
    end else begin
      tick_div <= tick_div + 1'b1;
      exec_tick <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_count <= '0;
    end else if (exec_tick) begin
      tick_count <= tick_count + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Function evaluation
  // ----------------------------------------------------------------
  // The enable and mode are sampled afresh on every tick, so toggling the enable
  // moves the output between the first operand and the function result.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        result[u] <= OPERAND_RESET;
      end
    end else if (exec_tick) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        result[u] <= compute(cfg[u]); // [RULE15] [RULE12] [RULE1]
      end
    end
  end

  assign unit0_result = result[0];
  assign unit1_result = result[1];

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign write_ok = (unit_of(aw_addr) < NUM_UNITS) && (aw_addr[1:0] == 2'h0)
                    && (aw_addr[3:0] != OFS_RESULT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        cfg[u].operand_a <= OPERAND_RESET; // [RULE13]
        cfg[u].operand_b <= OPERAND_RESET; // [RULE13]
        cfg[u].enable <= ENABLE_RESET; // [RULE13]
        cfg[u].mode <= MODE_RESET;
      end
    end else if (do_write && write_ok) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (unit_of(aw_addr) == u) begin
          case (aw_addr[3:0])
            OFS_OPERAND_A: begin
              cfg[u].operand_a <= merge_lanes(cfg[u].operand_a, w_data, w_strb);
            end
            OFS_OPERAND_B: begin
              cfg[u].operand_b <= merge_lanes(cfg[u].operand_b, w_data, w_strb);
            end
            OFS_CONTROL: begin
              if (w_strb[0]) begin
                cfg[u].enable <= w_data[CTRL_ENABLE_BIT];
                cfg[u].mode <= w_data[CTRL_MODE_LSB +: MODE_W];
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always_comb begin
    int unsigned u;
    u = unit_of(s_axi_araddr);
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    if (s_axi_araddr[1:0] != 2'h0) begin
      next_rresp = RESP_SLVERR;
    end else if (s_axi_araddr == OFS_TICK_COUNT) begin
      next_rdata = tick_count;
    end else if (u < NUM_UNITS) begin
      case (s_axi_araddr[3:0])
        OFS_OPERAND_A: next_rdata = cfg[u].operand_a;
        OFS_OPERAND_B: next_rdata = cfg[u].operand_b;
        OFS_CONTROL: begin
          next_rdata[CTRL_ENABLE_BIT] = cfg[u].enable;
          next_rdata[CTRL_MODE_LSB +: MODE_W] = cfg[u].mode;
        end
        OFS_RESULT: next_rdata = result[u];
        default: next_rresp = RESP_SLVERR;
      endcase
    end else begin
      next_rresp = RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// file: dual_fn_pkg.sv
// Constants, types and register map of the dual operand function unit.
package dual_fn_pkg;

  // ----------------------------------------------------------------
  // Bus and data widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NUM_UNITS = 2;
  localparam int unsigned MODE_W = 3;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_UNIT0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_UNIT1 = 8'h10;
  localparam logic [3:0] OFS_OPERAND_A = 4'h0;
  localparam logic [3:0] OFS_OPERAND_B = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h8;
  localparam logic [3:0] OFS_RESULT = 4'hc;
  localparam logic [ADDR_W-1:0] OFS_TICK_COUNT = 8'h20;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic signed [DATA_W-1:0] OPERAND_RESET = 32'h0000_0000;
  localparam logic ENABLE_RESET = 1'b0;
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;

  // Logical true is 1.00 in hundredths.
  localparam logic signed [DATA_W-1:0] FIXED_ONE = 32'h0000_0064;
  localparam logic signed [DATA_W-1:0] FIXED_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Execution tick timing
  // ----------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 20_000_000;
  localparam int unsigned TICK_TIME_US = 10;
  localparam int unsigned TICK_CYCLES = (TICK_TIME_US * (CLOCK_HZ / 1_000_000));
  localparam int unsigned TICK_W = 8;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [MODE_W-1:0] {
    MODE_SWITCH = 3'h0,
    MODE_LOGIC_INVERT = 3'h1,
    MODE_AND = 3'h2,
    MODE_OR = 3'h3,
    MODE_NEGATE_VALUE = 3'h4,
    MODE_MODULUS = 3'h5,
    MODE_COMPARATOR = 3'h6
  } fn_mode_t;

  typedef struct packed {
    logic signed [DATA_W-1:0] operand_a;
    logic signed [DATA_W-1:0] operand_b;
    logic enable;
    logic [MODE_W-1:0] mode;
  } unit_cfg_t;

endpackage

// file: dual_fn_assertions.sv
// Concurrent checks on the ports of the dual operand function unit.
`timescale 1ns/100ps
module dual_fn_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [dual_fn_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [dual_fn_pkg::DATA_W-1:0] unit0_result,
  input wire logic signed [dual_fn_pkg::DATA_W-1:0] unit1_result,
  input wire logic exec_tick
);
  import dual_fn_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_pulse;
    exec_tick ##1 !exec_tick [*8];
  endsequence
  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_tick_pulse: assert property (exec_tick |-> s_pulse)
    else $error("tick pulse too long");
  a_tick_period: assert property (exec_tick |-> ##200 exec_tick)
    else $error("tick period wrong");
  a_result_hold: assert property (!exec_tick |=>
    $stable(unit0_result) && $stable(unit1_result)) else $error("result moved off tick");
  a_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
    unit0_result == 32'h0 && unit1_result == 32'h0 && !exec_tick) else $error("reset state");
  a_write_answer: assert property (s_both_taken |=> ##1 s_axi_bvalid)
    else $error("no write response");
  a_write_stand: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  a_read_stand: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule
bind dual_operand_function_select dual_fn_assertions chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .unit0_result, .unit1_result, .exec_tick
);

// file: testbench.sv
// Self-checking testbench for the dual operand function unit.
`timescale 1ns/100ps
module testbench;
  import dual_fn_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exec_tick;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic signed [31:0] unit0_result, unit1_result;
  int err_total = 0, comparisons = 0, ticks = 0;
  logic [31:0] seed = 32'h0000_001e;
  always #25 aclk = ~aclk;
  always @(posedge aclk) if (aresetn && exec_tick) ticks <= ticks + 1;
  dual_operand_function_select uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .unit0_result, .unit1_result, .exec_tick
  );
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] ra(input int u, input logic [3:0] o);
    return (u != 0 ? OFS_UNIT1 : OFS_UNIT0) + {4'h0, o};
  endfunction
  function automatic logic [31:0] f_exp(input logic signed [31:0] a,
      input logic signed [31:0] b, input logic en, input logic [2:0] m);
    if (!en) return a;
    case (m)
      3'h0: return b;
      3'h1: return (a == 0) ? FIXED_ONE : FIXED_ZERO;
      3'h2: return (a != 0 && b != 0) ? FIXED_ONE : FIXED_ZERO;
      3'h3: return (a != 0 || b != 0) ? FIXED_ONE : FIXED_ZERO;
      3'h4: return -a;
      3'h5: return (a < 0) ? -a : a;
      3'h6: return (a > b) ? FIXED_ONE : FIXED_ZERO;
      default: return a;
    endcase
  endfunction
  task automatic wrap_up;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      wrap_up();
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    give_up(n, 50);
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    give_up(n, 50);
    check(s_axi_rdata, ed);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic wait_tick;
    int n;
    for (n = 0; n < 400; n++) begin
      @(posedge aclk);
      if (exec_tick === 1'b1) break;
    end
    give_up(n, 400);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic signed [31:0] a [2];
    logic signed [31:0] b [2];
    logic [31:0] ex [2];
    logic [2:0] m [2];
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int u = 0; u < 2; u++) begin
      rd_check(ra(u, OFS_OPERAND_A), 32'h0, RESP_OKAY);
      rd_check(ra(u, OFS_OPERAND_B), 32'h0, RESP_OKAY);
      rd_check(ra(u, OFS_CONTROL), 32'h0, RESP_OKAY);
    end
    rd_check(8'h24, 32'h0, RESP_SLVERR);
    rd_check(8'h02, 32'h0, RESP_SLVERR);
    axi_write(ra(0, OFS_RESULT), 32'h1234, RESP_SLVERR);
    axi_write(8'h30, 32'h1, RESP_SLVERR);
    rd_check(ra(0, OFS_RESULT), 32'h0, RESP_OKAY);
    for (int i = 0; i < 32; i++) begin
      wait_tick();
      for (int u = 0; u < 2; u++) begin
        seed = lfsr(seed);
        a[u] = {{10{seed[21]}}, seed[21:0]};
        seed = lfsr(seed);
        b[u] = {{10{seed[21]}}, seed[21:0]};
        if (i % 4 == 1) a[u] = 32'h0;
        if (i % 4 == 2) b[u] = a[u];
        m[u] = (u == 0) ? i[2:0] : ~i[2:0];
        axi_write(ra(u, OFS_OPERAND_A), a[u], RESP_OKAY);
        axi_write(ra(u, OFS_OPERAND_B), b[u], RESP_OKAY);
        axi_write(ra(u, OFS_CONTROL), {25'h0, m[u], 3'h0, i[3]}, RESP_OKAY);
        ex[u] = f_exp(a[u], b[u], i[3], m[u]);
      end
      wait_tick();
      @(posedge aclk);
      check(unit0_result, ex[0]);
      check(unit1_result, ex[1]);
      rd_check(ra(1, OFS_RESULT), ex[1], RESP_OKAY);
      rd_check(ra(0, OFS_CONTROL), {25'h0, m[0], 3'h0, i[3]}, RESP_OKAY);
      rd_check(OFS_TICK_COUNT, 32'(ticks), RESP_OKAY);
    end
    axi_write(ra(0, OFS_CONTROL), {25'h0, m[0], 4'h0}, RESP_OKAY);
    wait_tick();
    @(posedge aclk);
    check(unit0_result, a[0]);
    check(unit1_result, ex[1]);
    wrap_up();
  end
endmodule
